// ==== logic/ccr_map.vh ====
// Purpose: register offsets, field positions and reset values of the channel calibration bank
// Assumes: byte address = 4 * printed word index
// Notes: definitions only
`ifndef CCR_MAP_VH
`define CCR_MAP_VH

// ------------------------------------------------------------
// printed word indices
// ------------------------------------------------------------
`define CCR_IDX_CH6_OFS_HI 8'h28
`define CCR_IDX_CH6_OFS_LO 8'h29
`define CCR_IDX_CH6_GAIN_HI 8'h2A
`define CCR_IDX_CH6_GAIN_LO 8'h2B
`define CCR_IDX_CH7_SETUP 8'h2C
`define CCR_IDX_CH7_OFS_HI 8'h2D

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define CCR_RST_OFS_HI 16'h0000
`define CCR_RST_OFS_LO 8'h00
`define CCR_RST_GAIN_HI 16'h8000
`define CCR_RST_GAIN_LO 8'h00
`define CCR_RST_SETUP 16'h0000

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CCR_LO_FIELD_MSB 15
`define CCR_LO_FIELD_LSB 8
`define CCR_PHASE_MSB 15
`define CCR_PHASE_LSB 6
`define CCR_DCOFF_BIT 2
`define CCR_MUX_MSB 1
`define CCR_MUX_LSB 0
`define CCR_SETUP_WMASK 16'hFFC7

// ------------------------------------------------------------
// input select codes and bus answers
// ------------------------------------------------------------
`define CCR_MUX_PINS 2'h0
`define CCR_MUX_SHORT 2'h1
`define CCR_MUX_POS_TEST 2'h2
`define CCR_MUX_NEG_TEST 2'h3
`define CCR_RESP_OKAY 2'h0
`define CCR_RESP_SLVERR 2'h2

`endif

// ==== logic/ccr_cal_apply.v ====
// Purpose: applies offset and gain trim to a raw 24-bit conversion result
// Assumes: result = (raw - offset) * gain / 2^23, saturated to 24 bits
// Notes: one cycle of latency, valid travels with the data
`timescale 1ns/1ps
`default_nettype none

module ccr_cal_apply (
	input wire core_clk,
	input wire sys_rst,
	input wire raw_valid,
	input wire [23:0] raw_data,
	input wire [23:0] offset_trim,
	input wire [23:0] gain_trim,
	output reg cal_valid_r,
	output reg [23:0] cal_data_r
);

	wire signed [24:0] diff;
	wire signed [49:0] prod;
	wire signed [49:0] scaled;
	reg [23:0] cal_nxt;

	// subtract signed offset, multiply by unsigned gain, unity at 2^23
	assign diff = $signed({raw_data[23], raw_data}) - $signed({offset_trim[23], offset_trim});
	assign prod = diff * $signed({1'b0, gain_trim});
	assign scaled = prod >>> 23;

	// saturate to signed 24-bit range
	always @* begin
		if (scaled > 50'sd8388607) begin
			cal_nxt = 24'h7FFFFF;
		end else if (scaled < -50'sd8388608) begin
			cal_nxt = 24'h800000;
		end else begin
			cal_nxt = scaled[23:0];
		end
	end

	// output stage
	always @(posedge core_clk) begin
		if (sys_rst) begin
			cal_valid_r <= 1'b0;
			cal_data_r <= 24'h000000;
		end else begin
			cal_valid_r <= raw_valid;
			cal_data_r <= cal_nxt;
		end
	end

endmodule
`default_nettype wire

// ==== logic/ccr_bank.v ====
// Purpose: calibration and setup registers for channels six and seven over AXI4-Lite
// Assumes: one write and one read outstanding at most; inputs synchronous to core_clk
// Notes: channel six calibration is applied to its raw result stream
`timescale 1ns/1ps
`default_nettype none
`include "ccr_map.vh"

module ccr_bank (
	input wire core_clk,
	input wire sys_rst,
	input wire [9:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [9:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [3:0] global_dc_filter_setting,
	input wire ch6_raw_valid,
	input wire [23:0] ch6_raw_data,
	output reg ch6_cal_valid_r,
	output reg [23:0] ch6_cal_data_r,
	output reg [23:0] ch6_offset_trim_r,
	output reg [23:0] ch6_gain_trim_r,
	output reg [9:0] channel_phase_delay_r,
	output reg [1:0] channel_input_select_r,
	output reg channel_dc_filter_off_r,
	output reg [3:0] ch7_dc_filter_eff_r,
	output reg [15:0] ch7_offset_trim_upper_r
);

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	reg [15:0] ch6_ofs_hi_r;
	reg [7:0] ch6_ofs_lo_r;
	reg [15:0] ch6_gain_hi_r;
	reg [7:0] ch6_gain_lo_r;
	reg [15:0] ch7_setup_r;
	reg [15:0] ch7_ofs_hi_r;
	reg [9:0] aw_addr_r;
	reg aw_have_r;
	reg [31:0] w_data_r;
	reg [3:0] w_strb_r;
	reg w_have_r;

	// word address decode, used by both read and write paths
	function [2:0] reg_sel;
		input [9:0] addr;
		begin
			if (addr[1:0] != 2'h0) begin
				reg_sel = 3'h7;
			end else begin
				case (addr[9:2])
					`CCR_IDX_CH6_OFS_HI: reg_sel = 3'h0;
					`CCR_IDX_CH6_OFS_LO: reg_sel = 3'h1;
					`CCR_IDX_CH6_GAIN_HI: reg_sel = 3'h2;
					`CCR_IDX_CH6_GAIN_LO: reg_sel = 3'h3;
					`CCR_IDX_CH7_SETUP: reg_sel = 3'h4;
					`CCR_IDX_CH7_OFS_HI: reg_sel = 3'h5;
					default: reg_sel = 3'h7;
				endcase
			end
		end
	endfunction

	// byte-lane merge of a 16-bit register
	function [15:0] merge16;
		input [15:0] old;
		input [15:0] wd;
		input [1:0] st;
		begin
			merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
		end
	endfunction

	// ------------------------------------------------------------
	// write channel
	// ------------------------------------------------------------
	wire [9:0] wr_addr = aw_have_r ? aw_addr_r : s_axi_awaddr;
	wire [31:0] wr_data = w_have_r ? w_data_r : s_axi_wdata;
	wire [3:0] wr_strb = w_have_r ? w_strb_r : s_axi_wstrb;
	wire aw_ok = aw_have_r | (s_axi_awvalid & s_axi_awready);
	wire w_ok = w_have_r | (s_axi_wvalid & s_axi_wready);
	wire wr_go = aw_ok & w_ok & ~s_axi_bvalid;
	wire [2:0] wr_sel = reg_sel(wr_addr);
	wire [15:0] setup_merged = merge16(ch7_setup_r, wr_data[15:0], wr_strb[1:0]);

	// address and data taken in either order, response after both
	always @(posedge core_clk) begin
		if (sys_rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `CCR_RESP_OKAY;
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			aw_addr_r <= 10'h000;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_sel == 3'h7) ? `CCR_RESP_SLVERR : `CCR_RESP_OKAY;
			end else begin
				aw_have_r <= aw_ok;
				w_have_r <= w_ok;
				if (s_axi_bvalid & s_axi_bready) begin
					s_axi_bvalid <= 1'b0;
				end
			end
			s_axi_awready <= ~aw_ok & ~s_axi_awready & ~s_axi_bvalid;
			s_axi_wready <= ~w_ok & ~s_axi_wready & ~s_axi_bvalid;
		end
	end

	// ------------------------------------------------------------
	// register updates
	// ------------------------------------------------------------
	// one-hot strobe of the register a completed write lands in
	wire [7:0] wr_hit = {7'h00, wr_go} << wr_sel;

	// channel six offset trim, upper sixteen bits
	always @(posedge core_clk) begin
		if (sys_rst) begin
			ch6_ofs_hi_r <= `CCR_RST_OFS_HI;
		end else if (wr_hit[0]) begin
			ch6_ofs_hi_r <= merge16(ch6_ofs_hi_r, wr_data[15:0], wr_strb[1:0]);
		end
	end

	// channel six offset trim, low byte needs the upper lane strobe
	always @(posedge core_clk) begin
		if (sys_rst) begin
			ch6_ofs_lo_r <= `CCR_RST_OFS_LO;
		end else if (wr_hit[1] & wr_strb[1]) begin
			ch6_ofs_lo_r <= wr_data[15:8];
		end
	end

	// channel six gain trim, upper sixteen bits
	always @(posedge core_clk) begin
		if (sys_rst) begin
			ch6_gain_hi_r <= `CCR_RST_GAIN_HI;
		end else if (wr_hit[2]) begin
			ch6_gain_hi_r <= merge16(ch6_gain_hi_r, wr_data[15:0], wr_strb[1:0]);
		end
	end

	// channel six gain trim, low byte needs the upper lane strobe
	always @(posedge core_clk) begin
		if (sys_rst) begin
			ch6_gain_lo_r <= `CCR_RST_GAIN_LO;
		end else if (wr_hit[3] & wr_strb[1]) begin
			ch6_gain_lo_r <= wr_data[15:8];
		end
	end

	// channel seven setup, reserved bits never stored
	always @(posedge core_clk) begin
		if (sys_rst) begin
			ch7_setup_r <= `CCR_RST_SETUP;
		end else if (wr_hit[4]) begin
			ch7_setup_r <= setup_merged & `CCR_SETUP_WMASK;
		end
	end

	// channel seven offset trim, upper sixteen bits
	always @(posedge core_clk) begin
		if (sys_rst) begin
			ch7_ofs_hi_r <= `CCR_RST_OFS_HI;
		end else if (wr_hit[5]) begin
			ch7_ofs_hi_r <= merge16(ch7_ofs_hi_r, wr_data[15:0], wr_strb[1:0]);
		end
	end

	// ------------------------------------------------------------
	// read channel
	// ------------------------------------------------------------
	reg [15:0] rd_val;
	wire [2:0] rd_sel = reg_sel(s_axi_araddr);

	// read mux, low bytes of trim low registers read zero
	always @* begin
		case (rd_sel)
			3'h0: rd_val = ch6_ofs_hi_r;
			3'h1: rd_val = {ch6_ofs_lo_r, 8'h00};
			3'h2: rd_val = ch6_gain_hi_r;
			3'h3: rd_val = {ch6_gain_lo_r, 8'h00};
			3'h4: rd_val = ch7_setup_r & `CCR_SETUP_WMASK;
			3'h5: rd_val = ch7_ofs_hi_r;
			default: rd_val = 16'h0000;
		endcase
	end

	// single outstanding read, one cycle answer
	always @(posedge core_clk) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `CCR_RESP_OKAY;
		end else begin
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {16'h0000, rd_val};
				s_axi_rresp <= (rd_sel == 3'h7) ? `CCR_RESP_SLVERR : `CCR_RESP_OKAY;
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
		end
	end

	// ------------------------------------------------------------
	// control outputs
	// ------------------------------------------------------------
	// field split and combined trim words
	always @(posedge core_clk) begin
		if (sys_rst) begin
			ch6_offset_trim_r <= 24'h000000;
			ch6_gain_trim_r <= {`CCR_RST_GAIN_HI, `CCR_RST_GAIN_LO};
			channel_phase_delay_r <= 10'h000;
			channel_input_select_r <= `CCR_MUX_PINS;
			channel_dc_filter_off_r <= 1'b0;
			ch7_dc_filter_eff_r <= 4'h0;
			ch7_offset_trim_upper_r <= 16'h0000;
		end else begin
			ch6_offset_trim_r <= {ch6_ofs_hi_r, ch6_ofs_lo_r};
			ch6_gain_trim_r <= {ch6_gain_hi_r, ch6_gain_lo_r};
			channel_phase_delay_r <= ch7_setup_r[`CCR_PHASE_MSB:`CCR_PHASE_LSB];
			channel_input_select_r <= ch7_setup_r[`CCR_MUX_MSB:`CCR_MUX_LSB];
			channel_dc_filter_off_r <= ch7_setup_r[`CCR_DCOFF_BIT];
			ch7_dc_filter_eff_r <= ch7_setup_r[`CCR_DCOFF_BIT] ? 4'h0 : global_dc_filter_setting;
			ch7_offset_trim_upper_r <= ch7_ofs_hi_r;
		end
	end

	// ------------------------------------------------------------
	// channel six calibration datapath
	// ------------------------------------------------------------
	wire cal_valid;
	wire [23:0] cal_data;

	ccr_cal_apply u_cal (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.raw_valid(ch6_raw_valid),
		.raw_data(ch6_raw_data),
		.offset_trim(ch6_offset_trim_r),
		.gain_trim(ch6_gain_trim_r),
		.cal_valid_r(cal_valid),
		.cal_data_r(cal_data)
	);

	// retime so the top output comes from a flop
	always @(posedge core_clk) begin
		if (sys_rst) begin
			ch6_cal_valid_r <= 1'b0;
			ch6_cal_data_r <= 24'h000000;
		end else begin
			ch6_cal_valid_r <= cal_valid;
			ch6_cal_data_r <= cal_data;
		end
	end

endmodule
`default_nettype wire

// ==== bench/ccr_bank_assertions.sv ====
// Purpose: port-level checks of the channel calibration bank
// Assumes: single clock, synchronous active-high reset
// Notes: bound into ccr_bank below
`timescale 1ns/1ps
`default_nettype none
module ccr_bank_checker (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [3:0] global_dc_filter_setting,
	input wire logic channel_dc_filter_off_r,
	input wire logic [3:0] ch7_dc_filter_eff_r,
	input wire logic ch6_raw_valid,
	input wire logic ch6_cal_valid_r,
	input wire logic [23:0] ch6_offset_trim_r,
	input wire logic [23:0] ch6_gain_trim_r
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// bus answers
	property p_ar_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_ar_answer: assert property (p_ar_answer) else $error("read not answered");
	property p_rdata_upper; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
	a_rdata_upper: assert property (p_rdata_upper) else $error("upper read bits set");
	property p_ar_cause; $rose(s_axi_arready) |-> $past(s_axi_arvalid); endproperty
	a_ar_cause: assert property (p_ar_cause) else $error("arready without request");
	property p_b_blocks_aw; s_axi_bvalid |-> !s_axi_awready; endproperty
	a_b_blocks_aw: assert property (p_b_blocks_aw) else $error("write taken while pending");
	// derived outputs
	property p_dc_eff;
		$past(sys_rst) || ch7_dc_filter_eff_r == (channel_dc_filter_off_r ? 4'h0 : $past(global_dc_filter_setting));
	endproperty
	a_dc_eff: assert property (p_dc_eff) else $error("dc filter code wrong");
	property p_cal_lat; ch6_raw_valid |-> ##2 ch6_cal_valid_r; endproperty
	a_cal_lat: assert property (p_cal_lat) else $error("calibrated result late");
	property p_cal_only; ch6_cal_valid_r |-> $past(ch6_raw_valid, 2); endproperty
	a_cal_only: assert property (p_cal_only) else $error("spurious calibrated result");
	property p_trim_reset; $fell(sys_rst) |-> ch6_gain_trim_r == 24'h800000 && ch6_offset_trim_r == 24'h000000; endproperty
	a_trim_reset: assert property (p_trim_reset) else $error("trim reset value wrong");
endmodule
bind ccr_bank ccr_bank_checker chk_u (.core_clk, .sys_rst, .s_axi_awready, .s_axi_bvalid, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .global_dc_filter_setting, .channel_dc_filter_off_r,
	.ch7_dc_filter_eff_r, .ch6_raw_valid, .ch6_cal_valid_r, .ch6_offset_trim_r, .ch6_gain_trim_r);
`default_nettype wire

// ==== bench/ccr_bank_bench.sv ====
// Purpose: self-checking bench for the channel calibration bank
// Assumes: AXI4-Lite master with bready and rready held high
// Notes: expectations built from the field layout
`timescale 1ns/1ps
`default_nettype none
module ccr_bank_bench;
	logic core_clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, ch6_raw_valid, ch6_cal_valid_r;
	logic channel_dc_filter_off_r;
	logic [9:0] s_axi_awaddr, s_axi_araddr, channel_phase_delay_r;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
	logic [3:0] s_axi_wstrb, global_dc_filter_setting, ch7_dc_filter_eff_r;
	logic [1:0] s_axi_bresp, s_axi_rresp, channel_input_select_r, rsp;
	logic [23:0] ch6_raw_data, ch6_cal_data_r, ch6_offset_trim_r, ch6_gain_trim_r;
	logic [15:0] ch7_offset_trim_upper_r;
	logic [7:0] idx_t [6] = '{8'h28, 8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2D};
	logic [15:0] rst_t [6] = '{16'h0000, 16'h0000, 16'h8000, 16'h0000, 16'h0000, 16'h0000};
	logic [15:0] one_t [6] = '{16'hFFFF, 16'hFF00, 16'hFFFF, 16'hFF00, 16'hFFC7, 16'hFFFF};
	int fail_count, num_checks, i;

	ccr_bank dut_u (.core_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.global_dc_filter_setting, .ch6_raw_valid, .ch6_raw_data, .ch6_cal_valid_r, .ch6_cal_data_r,
		.ch6_offset_trim_r, .ch6_gain_trim_r, .channel_phase_delay_r, .channel_input_select_r,
		.channel_dc_filter_off_r, .ch7_dc_filter_eff_r, .ch7_offset_trim_upper_r);

	// 200 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	task close_out;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task chk(input logic [47:0] got, input logic [47:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, got, exp);
		end
	endtask

	// one write, both channels offered together
	task wr(input logic [7:0] idx, input logic [15:0] d);
		int n;
		s_axi_awaddr <= {idx, 2'h0};
		s_axi_wdata <= {16'h0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			n++;
		end while (s_axi_bvalid !== 1'b1 && n < 40);
		rsp = s_axi_bresp;
		if (n >= 40) begin fail_count++; close_out; end
	endtask

	task rd(input logic [7:0] idx);
		int n;
		s_axi_araddr <= {idx, 2'h0};
		s_axi_arvalid <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			n++;
		end while (s_axi_rvalid !== 1'b1 && n < 40);
		rd_v = s_axi_rdata;
		rsp = s_axi_rresp;
		if (n >= 40) begin fail_count++; close_out; end
	endtask

	task do_reset;
		sys_rst <= 1'b1;
		repeat (8) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
	endtask

	// main sequence
	initial begin
		{sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, ch6_raw_valid} = 5'h10;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, ch6_raw_data} = '0;
		{s_axi_bready, s_axi_rready, s_axi_wstrb, global_dc_filter_setting} = 10'h3FA;
		do_reset;
		for (i = 0; i < 6; i++) begin
			rd(idx_t[i]);
			chk({rsp, rd_v}, rst_t[i]);
		end
		chk({ch6_gain_trim_r, ch6_offset_trim_r}, 48'h800000000000);
		for (i = 0; i < 6; i++) begin
			wr(idx_t[i], 16'hFFFF);
			rd(idx_t[i]);
			chk({rsp, rd_v}, one_t[i]);
		end
		wr(8'h2E, 16'h1234);
		chk(rsp, 2'h2);
		rd(8'h2E);
		chk({rsp, rd_v}, {2'h2, 32'h0});
		wr(8'h28, 16'h8123);
		wr(8'h29, 16'hA5FF);
		wr(8'h2A, 16'h1234);
		wr(8'h2B, 16'h56FF);
		wr(8'h2D, 16'hBEEF);
		chk(rsp, 2'h0);
		repeat (2) @(posedge core_clk);
		chk({ch6_offset_trim_r, ch6_gain_trim_r}, 48'h8123A5123456);
		chk(ch7_offset_trim_upper_r, 16'hBEEF);
		for (i = 0; i < 4; i++) begin
			wr(8'h2C, {8'h80, i[1:0], 3'h7, i[0], i[1:0]});
			repeat (2) @(posedge core_clk);
			chk({channel_phase_delay_r, channel_dc_filter_off_r, channel_input_select_r, ch7_dc_filter_eff_r},
				{8'h80, i[1:0], i[0], i[1:0], i[0] ? 4'h0 : 4'hA});
			rd(8'h2C);
			chk(rd_v, {8'h80, i[1:0], 3'h0, i[0], i[1:0]});
		end
		// offset 0x10, gain one half
		wr(8'h28, 16'h0000);
		wr(8'h29, 16'h1000);
		wr(8'h2A, 16'h4000);
		wr(8'h2B, 16'h0000);
		repeat (2) @(posedge core_clk);
		ch6_raw_data <= 24'h000100;
		ch6_raw_valid <= 1'b1;
		@(posedge core_clk);
		ch6_raw_valid <= 1'b0;
		@(posedge core_clk);
		@(negedge core_clk);
		chk({ch6_cal_valid_r, ch6_cal_data_r}, {1'b1, 24'h000078});
		@(posedge core_clk);
		// lower lane only: low registers keep their byte, high words take bits 7:0
		s_axi_wstrb <= 4'h1;
		wr(8'h29, 16'h0000);
		rd(8'h29);
		chk(rd_v, 16'h1000);
		wr(8'h28, 16'hFFAA);
		rd(8'h28);
		chk(rd_v, 16'h00AA);
		s_axi_wstrb <= 4'hF;
		do_reset;
		rd(8'h2A);
		chk(rd_v, 16'h8000);
		rd(8'h2C);
		chk(rd_v, 16'h0000);
		close_out;
	end
endmodule
`default_nettype wire
